// ### rtl/ueflow_defs.svh
`ifndef UEFLOW_DEFS_SVH
`define UEFLOW_DEFS_SVH
// ==========================================
// register byte offsets
`define UEF_AW        8
`define UEF_A_SCRATCH 8'h00
`define UEF_A_EFR     8'h04
`define UEF_A_RES1    8'h08
`define UEF_A_RES2    8'h0c
`define UEF_A_PAU1    8'h10
`define UEF_A_PAU2    8'h14
`define UEF_A_IER     8'h18
`define UEF_A_ISR     8'h1c
`define UEF_A_FCR     8'h20
`define UEF_A_MCR     8'h24
`define UEF_A_STAT    8'h28
// ==========================================
// field positions and masks
`define UEF_EFR_ACTS  7
`define UEF_EFR_ARTS  6
`define UEF_EFR_SPC   5
`define UEF_EFR_ENH   4
`define UEF_EFR_TX    3:2
`define UEF_EFR_RX    1:0
`define UEF_FCR_TRIG  5:4
`define UEF_MCR_RTS   1
`define UEF_ISR_F     5:4
`define UEF_ISR_SPC   0
`define UEF_M_IER     8'hf0
`define UEF_M_FCR     8'h30
`define UEF_M_MCR     8'he0
`define UEF_HT_ACT    1
// ==========================================
// reset values and mode codes
`define UEF_RST8      8'h00
`define UEF_RST2      2'b00
`define UEF_FC_NONE   2'b00
`define UEF_FC_P1     2'b10
`define UEF_FC_P2     2'b01
`define UEF_FC_BOTH   2'b11
// ==========================================
// receive fifo trigger levels
`define UEF_LW        7
`define UEF_TRIG0     8
`define UEF_TRIG1     16
`define UEF_TRIG2     56
`define UEF_TRIG3     60
`endif

// ### rtl/ueflow_pkg.sv
package ueflow_pkg;
  // ==========================================
  // flow character sender states
  typedef enum logic [1:0]
  {
    UEF_IDLE  = 2'b00,
    UEF_SEND1 = 2'b01,
    UEF_SEND2 = 2'b11
  } ueflow_tx_st_t;
  typedef enum logic {UEF_K_PAUSE, UEF_K_RESUME} ueflow_kind_t;
endpackage

// ### rtl/ueflow_ln_if.sv
`timescale 1ns/1ps
interface ueflow_ln_if #(parameter int LW = 7);
  logic          rx_valid;
  logic [7:0]    rx_data;
  logic [LW-1:0] rx_level;
  logic [7:0]    res1, res2, pau1, pau2;
  logic [1:0]    rx_mode, trig_sel;
  logic          spc_en, auto_rts, sw_rts;
  logic          pause_hit, resume_hit, special_hit;
  logic          rx_high, rx_low, rts_n, trig_int;
  modport top (output rx_valid, rx_data, rx_level, res1, res2, pau1, pau2,
               rx_mode, trig_sel, spc_en, auto_rts, sw_rts,
               input pause_hit, resume_hit, special_hit, rx_high, rx_low,
               rts_n, trig_int);
  modport match (input rx_valid, rx_data, res1, res2, pau1, pau2, rx_mode,
                 spc_en, output pause_hit, resume_hit, special_hit);
  modport rts (input rx_level, trig_sel, auto_rts, sw_rts,
               output rx_high, rx_low, rts_n, trig_int);
endinterface

// ### rtl/ueflow_char_match.sv
`timescale 1ns/1ps
`include "ueflow_defs.svh"
module ueflow_char_match
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  ueflow_ln_if.match ln
);
  logic res_m;
  logic pau_m;
  logic prev_res1_q;
  logic prev_pau1_q;

  // ==========================================
  // compare select
  always_comb
  begin
    res_m = 1'b0;
    pau_m = 1'b0;
    // R17: single pair compare
    // R11: bit i against bit i
    unique case (ln.rx_mode)
      `UEF_FC_P1:
      begin
        res_m = ln.rx_data == ln.res1;
        pau_m = ln.rx_data == ln.pau1;
      end
      `UEF_FC_P2:
      begin
        res_m = ln.rx_data == ln.res2;
        pau_m = ln.rx_data == ln.pau2;
      end
      // R18: two character sequences
      // R15: ordered pair match
      `UEF_FC_BOTH:
      begin
        res_m = prev_res1_q && ln.rx_data == ln.res2;
        pau_m = prev_pau1_q && ln.rx_data == ln.pau2;
      end
      `UEF_FC_NONE:
      begin
        res_m = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_res1_q    <= 1'b0;
      prev_pau1_q    <= 1'b0;
      ln.pause_hit   <= 1'b0;
      ln.resume_hit  <= 1'b0;
      ln.special_hit <= 1'b0;
    end
    else if (ce)
    begin
      if (ln.rx_valid)
      begin
        prev_res1_q <= ln.rx_data == ln.res1;
        prev_pau1_q <= ln.rx_data == ln.pau1;
      end
      ln.pause_hit   <= ln.rx_valid && pau_m;
      ln.resume_hit  <= ln.rx_valid && res_m;
      // R9: special char compare
      ln.special_hit <= ln.rx_valid && ln.spc_en && ln.rx_data == ln.pau2;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);
  sequence s_pau_pair;
    ln.rx_mode == `UEF_FC_BOTH && ln.rx_valid && ln.rx_data == ln.pau1
    ##1 !ln.rx_valid
    ##1 ln.rx_mode == `UEF_FC_BOTH && ln.rx_valid && ln.rx_data == ln.pau2;
  endsequence
  property p_pau_pair;
    s_pau_pair |=> ln.pause_hit;
  endproperty
  a_pau_pair: assert property (p_pau_pair) else $error("pair not matched"); // R18
  property p_spc;
    ln.rx_valid && ln.spc_en && ln.rx_data == ln.pau2 |=> ln.special_hit;
  endproperty
  a_spc: assert property (p_spc) else $error("special char missed"); // R9
  property p_spc_off;
    !ln.spc_en |=> !ln.special_hit;
  endproperty
  a_spc_off: assert property (p_spc_off) else $error("detect while off"); // R9
endmodule

// ### rtl/ueflow_rts_ctrl.sv
`timescale 1ns/1ps
`include "ueflow_defs.svh"
module ueflow_rts_ctrl #(
  parameter int            LW = `UEF_LW,
  parameter logic [LW-1:0] T0 = LW'(`UEF_TRIG0),
  parameter logic [LW-1:0] T1 = LW'(`UEF_TRIG1),
  parameter logic [LW-1:0] T2 = LW'(`UEF_TRIG2),
  parameter logic [LW-1:0] T3 = LW'(`UEF_TRIG3)
)
(
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  ueflow_ln_if.rts  ln
);
  logic [LW-1:0] trig;
  logic [LW-1:0] nxt;
  logic          hi;
  logic          lo;
  logic          hi_q;
  logic          lo_q;

  // ==========================================
  // trigger level pick
  always_comb
  begin
    unique case (ln.trig_sel)
      2'd0:
      begin
        trig = T0;
        nxt  = T1;
      end
      2'd1:
      begin
        trig = T1;
        nxt  = T2;
      end
      2'd2:
      begin
        trig = T2;
        nxt  = T3;
      end
      2'd3:
      begin
        trig = T3;
        nxt  = T3;
      end
    endcase
  end
  assign hi = ln.rx_level >= nxt;
  assign lo = {1'b0, ln.rx_level} + {{LW{1'b0}}, 1'b1} < {1'b0, trig};

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hi_q        <= 1'b0;
      lo_q        <= 1'b1;
      ln.rx_high  <= 1'b0;
      ln.rx_low   <= 1'b0;
      ln.rts_n    <= 1'b1;
      ln.trig_int <= 1'b0;
    end
    else if (ce)
    begin
      hi_q       <= hi;
      lo_q       <= lo;
      ln.rx_high <= hi && !hi_q;
      ln.rx_low  <= lo && !lo_q;
      // R5: trigger level interrupt
      ln.trig_int <= ln.auto_rts && ln.rx_level >= trig;
      // R8: software rts
      if (!ln.auto_rts)
        ln.rts_n <= !ln.sw_rts;
      // R6: raise at next level
      else if (hi)
        ln.rts_n <= 1'b1;
      // R7: drop below trigger minus one
      else if (lo)
        ln.rts_n <= 1'b0;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);
  property p_rts_hi;
    ln.auto_rts && ln.rx_level >= nxt |=> ln.rts_n;
  endproperty
  a_rts_hi: assert property (p_rts_hi) else $error("rts not raised"); // R6
  property p_rts_lo;
    ln.auto_rts && !hi && lo |=> !ln.rts_n;
  endproperty
  a_rts_lo: assert property (p_rts_lo) else $error("rts not dropped"); // R7
  property p_rts_sw;
    !ln.auto_rts |=> ln.rts_n == !$past(ln.sw_rts);
  endproperty
  a_rts_sw: assert property (p_rts_sw) else $error("rts not software"); // R8
  property p_trig;
    ln.auto_rts && ln.rx_level >= trig |=> ln.trig_int;
  endproperty
  a_trig: assert property (p_trig) else $error("trigger irq missed"); // R5
endmodule

// ### rtl/ueflow_top.sv
// Behaviour
// R1: scratch byte reads back what was written
// R2: auto cts set, cts high halts transmit
// R3: cts low again resumes transmit
// R4: halt only after current character ends
// R5: auto rts raises irq at trigger
// R6: rts high at next trigger level
// R7: rts low below trigger minus one
// R8: rts follows software when auto off
// R9: special detect compares with second pause
// R10: matched char kept, source flag set
// R11: char bit zero matches register bit zero
// R12: software clears flow bits before detect
// R13: enhanced bits writable only while unlocked
// R14: clearing unlock bit latches enhanced bits
// R15: dual mode pairs form one sequence
// R16: tx flow bits choose sent pair
// R17: rx flow bits choose compared pair
// R18: both rx bits compare two-char sequences
// R19: flow bits reset to zero
// R20: flow chars never used as data
// R21: matched pause stops, resume restarts
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "ueflow_defs.svh"
module ueflow_top #(
  parameter int LW = `UEF_LW
)
(
  input  wire logic          core_clk,
  input  wire logic          nrst,
  input  wire logic          ce,
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  input  wire logic          cts_n,
  output wire logic          rts_n,
  output wire logic          rx_trig_int,
  input  wire logic          rx_valid,
  input  wire logic [7:0]    rx_data,
  input  wire logic [LW-1:0] rx_level,
  input  wire logic          tx_busy,
  output logic               tx_enable,
  output logic               fc_valid,
  output logic      [7:0]    fc_char,
  input  wire logic          fc_ready
);
  logic                      rs1_q;
  logic                      rst_n;
  logic                      acc;
  logic                      we;
  logic                      wr_pend_q;
  logic [`UEF_AW-1:0]        haddr_q;
  logic [7:0]                wdat;
  logic [31:0]               rdata_c;
  logic [7:0]                scratch_q;
  logic [7:0]                efr_q;
  logic [7:0]                res1_q;
  logic [7:0]                res2_q;
  logic [7:0]                pau1_q;
  logic [7:0]                pau2_q;
  logic [7:0]                ier_q;
  logic [7:0]                fcr_q;
  logic [7:0]                mcr_q;
  logic [1:0]                isr_q;
  logic                      enh;
  logic                      sw_pause_q;
  logic                      stop;
  logic                      fc_pend_q;
  ueflow_pkg::ueflow_kind_t  kind_q;
  ueflow_pkg::ueflow_tx_st_t st_q;
  logic [7:0]                c1;
  logic [7:0]                c2;

  ueflow_ln_if #(.LW(LW)) ln ();

  // ==========================================
  // reset release
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end

  // ==========================================
  // ahb-lite slave
  assign acc  = hsel && htrans[`UEF_HT_ACT] && hready;
  assign we   = wr_pend_q && ce;
  assign wdat = hwdata[7:0];
  assign enh  = efr_q[`UEF_EFR_ENH];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      haddr_q   <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
    end
    else if (ce)
    begin
      wr_pend_q <= acc && hwrite;
      hreadyout <= !(acc && hwrite);
      hresp     <= 1'b0;
      if (acc)
        haddr_q <= haddr[`UEF_AW-1:0];
      if (acc && !hwrite)
        hrdata <= rdata_c;
    end
  end

  always_comb
  begin
    rdata_c = '0;
    if (haddr[31:`UEF_AW] == '0)
    begin
      case (haddr[`UEF_AW-1:0])
        `UEF_A_SCRATCH: rdata_c[7:0] = scratch_q;
        `UEF_A_EFR:     rdata_c[7:0] = efr_q;
        `UEF_A_RES1:    rdata_c[7:0] = res1_q;
        `UEF_A_RES2:    rdata_c[7:0] = res2_q;
        `UEF_A_PAU1:    rdata_c[7:0] = pau1_q;
        `UEF_A_PAU2:    rdata_c[7:0] = pau2_q;
        `UEF_A_IER:     rdata_c[7:0] = ier_q;
        `UEF_A_ISR:     rdata_c[7:0] = {2'b00, isr_q, 3'b000, ~|isr_q};
        `UEF_A_FCR:     rdata_c[7:0] = fcr_q;
        `UEF_A_MCR:     rdata_c[7:0] = mcr_q;
        `UEF_A_STAT:
          rdata_c[7:0] = {1'b0, fc_pend_q, st_q, sw_pause_q, tx_enable, rts_n, cts_n};
        default:        rdata_c = '0;
      endcase
    end
  end

  // ==========================================
  // register file
  function automatic logic [7:0] gate_w(input logic [7:0] old, input logic [7:0] nw,
                                        input logic [7:0] msk, input logic en);
    gate_w = en ? nw : ((nw & ~msk) | (old & msk));
  endfunction

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scratch_q <= `UEF_RST8;
      // R19: flow bits start cleared
      efr_q     <= `UEF_RST8;
      res1_q    <= `UEF_RST8;
      res2_q    <= `UEF_RST8;
      pau1_q    <= `UEF_RST8;
      pau2_q    <= `UEF_RST8;
      ier_q     <= `UEF_RST8;
      fcr_q     <= `UEF_RST8;
      mcr_q     <= `UEF_RST8;
    end
    else if (we)
    begin
      case (haddr_q)
        // R1: plain scratch storage
        `UEF_A_SCRATCH: scratch_q <= wdat;
        `UEF_A_EFR:     efr_q     <= wdat;
        `UEF_A_RES1:    res1_q    <= wdat;
        `UEF_A_RES2:    res2_q    <= wdat;
        `UEF_A_PAU1:    pau1_q    <= wdat;
        `UEF_A_PAU2:    pau2_q    <= wdat;
        // R13: enhanced bits gated
        // R14: locked once unlock cleared
        `UEF_A_IER:     ier_q <= gate_w(ier_q, wdat, `UEF_M_IER, enh);
        `UEF_A_FCR:     fcr_q <= gate_w(fcr_q, wdat, `UEF_M_FCR, enh);
        `UEF_A_MCR:     mcr_q <= gate_w(mcr_q, wdat, `UEF_M_MCR, enh);
        default:        scratch_q <= scratch_q;
      endcase
    end
  end

  // ==========================================
  // interrupt source flags
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      isr_q <= `UEF_RST2;
    else if (ce)
    begin
      // R13: source bits gated
      if (we && haddr_q == `UEF_A_ISR && enh)
        isr_q <= wdat[`UEF_ISR_F];
      // R10: flag special char
      if (ln.special_hit)
        isr_q[`UEF_ISR_SPC] <= 1'b1;
    end
  end

  // ==========================================
  // line side wiring
  assign ln.rx_valid = rx_valid;
  assign ln.rx_data  = rx_data;
  assign ln.rx_level = rx_level;
  assign ln.res1     = res1_q;
  assign ln.res2     = res2_q;
  assign ln.pau1     = pau1_q;
  assign ln.pau2     = pau2_q;
  assign ln.rx_mode  = efr_q[`UEF_EFR_RX];
  assign ln.trig_sel = fcr_q[`UEF_FCR_TRIG];
  assign ln.spc_en   = efr_q[`UEF_EFR_SPC];
  assign ln.auto_rts = efr_q[`UEF_EFR_ARTS];
  assign ln.sw_rts   = mcr_q[`UEF_MCR_RTS];
  assign rts_n       = ln.rts_n;
  assign rx_trig_int = ln.trig_int;

  ueflow_char_match u_ueflow_char_match
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .ln       (ln.match)
  );

  ueflow_rts_ctrl #(.LW(LW)) u_ueflow_rts_ctrl
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .ce       (ce),
    .ln       (ln.rts)
  );

  // ==========================================
  // software pause from received chars
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      sw_pause_q <= 1'b0;
    else if (ce)
    begin
      // R21: pause and resume chars
      if (ln.rx_mode == `UEF_FC_NONE)
        sw_pause_q <= 1'b0;
      else if (ln.pause_hit)
        sw_pause_q <= 1'b1;
      else if (ln.resume_hit)
        sw_pause_q <= 1'b0;
    end
  end

  // ==========================================
  // transmit gate
  // R2: cts high halts
  assign stop = (efr_q[`UEF_EFR_ACTS] && cts_n) || sw_pause_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_enable <= 1'b0;
    // R4: hold while char shifts
    // R3: resume on cts low
    else if (ce && !tx_busy)
      tx_enable <= !stop && st_q == ueflow_pkg::UEF_IDLE && !fc_pend_q;
  end

  // ==========================================
  // flow character sender
  assign c1 = (kind_q == ueflow_pkg::UEF_K_PAUSE) ? pau1_q : res1_q;
  assign c2 = (kind_q == ueflow_pkg::UEF_K_PAUSE) ? pau2_q : res2_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fc_pend_q <= 1'b0;
      kind_q    <= ueflow_pkg::UEF_K_PAUSE;
    end
    else if (ce)
    begin
      if (ln.rx_high && efr_q[`UEF_EFR_TX] != `UEF_FC_NONE)
      begin
        fc_pend_q <= 1'b1;
        kind_q    <= ueflow_pkg::UEF_K_PAUSE;
      end
      else if (ln.rx_low && efr_q[`UEF_EFR_TX] != `UEF_FC_NONE)
      begin
        fc_pend_q <= 1'b1;
        kind_q    <= ueflow_pkg::UEF_K_RESUME;
      end
      else if (st_q == ueflow_pkg::UEF_IDLE)
        fc_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q     <= ueflow_pkg::UEF_IDLE;
      fc_valid <= 1'b0;
      fc_char  <= `UEF_RST8;
    end
    else if (ce)
    begin
      // R16: pair chosen by tx bits
      // R15: both chars in order
      unique case (st_q)
        ueflow_pkg::UEF_IDLE:
          if (fc_pend_q)
          begin
            st_q     <= ueflow_pkg::UEF_SEND1;
            fc_valid <= 1'b1;
            fc_char  <= (efr_q[`UEF_EFR_TX] == `UEF_FC_P2) ? c2 : c1;
          end
        ueflow_pkg::UEF_SEND1:
          if (fc_ready && efr_q[`UEF_EFR_TX] == `UEF_FC_BOTH)
          begin
            st_q    <= ueflow_pkg::UEF_SEND2;
            fc_char <= c2;
          end
          else if (fc_ready)
          begin
            st_q     <= ueflow_pkg::UEF_IDLE;
            fc_valid <= 1'b0;
          end
        ueflow_pkg::UEF_SEND2:
          if (fc_ready)
          begin
            st_q     <= ueflow_pkg::UEF_IDLE;
            fc_valid <= 1'b0;
          end
        default:
        begin
          st_q     <= ueflow_pkg::UEF_IDLE;
          fc_valid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n || !ce);
  property p_scratch;
    we && haddr_q == `UEF_A_SCRATCH |=> scratch_q == $past(hwdata[7:0]);
  endproperty
  a_scratch: assert property (p_scratch) else $error("scratch lost"); // R1
  property p_cts_halt;
    efr_q[`UEF_EFR_ACTS] && cts_n && !tx_busy |=> !tx_enable;
  endproperty
  a_cts_halt: assert property (p_cts_halt) else $error("cts halt missed"); // R2
  property p_cts_go;
    efr_q[`UEF_EFR_ACTS] && !cts_n && !sw_pause_q && !tx_busy && !fc_pend_q
      && st_q == ueflow_pkg::UEF_IDLE |=> tx_enable;
  endproperty
  a_cts_go: assert property (p_cts_go) else $error("no resume"); // R3
  property p_hold;
    tx_busy |=> tx_enable == $past(tx_enable);
  endproperty
  a_hold: assert property (p_hold) else $error("gate moved mid char"); // R4
  property p_ier_lock;
    we && haddr_q == `UEF_A_IER && !enh |=> ier_q[7:4] == $past(ier_q[7:4]);
  endproperty
  a_ier_lock: assert property (p_ier_lock) else $error("locked bits written"); // R13
  property p_spc_flag;
    ln.special_hit |=> isr_q[`UEF_ISR_SPC];
  endproperty
  a_spc_flag: assert property (p_spc_flag) else $error("source flag missed"); // R10
  sequence s_first_out;
    st_q == ueflow_pkg::UEF_SEND1 && fc_ready && efr_q[`UEF_EFR_TX] == `UEF_FC_BOTH;
  endsequence
  property p_pair;
    s_first_out |=> fc_valid && fc_char == $past(c2);
  endproperty
  a_pair: assert property (p_pair) else $error("second char missing"); // R15
  property p_pause;
    ln.pause_hit && ln.rx_mode != `UEF_FC_NONE ##1 !tx_busy |=> !tx_enable;
  endproperty
  a_pause: assert property (p_pause) else $error("pause ignored"); // R21
endmodule

// ### tb/ueflow_remote.sv
`timescale 1ns/1ps
module ueflow_remote
(
  input  wire logic       core_clk,
  input  wire logic       rts_n,
  input  wire logic       fc_valid,
  input  wire logic [7:0] fc_char,
  output logic            cts_n,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            fc_ready,
  output logic            tx_busy
);
  logic [7:0] got[$];
  int         slow = 0;
  int         cnt = 0;
  initial
  begin
    cts_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    fc_ready = 1'b0;
    tx_busy = 1'b0;
  end
  // ==========================================
  // flow chars accepted once fc_ready rises, slow plus one cycles after fc_valid
  always @(posedge core_clk)
  begin
    if (fc_valid === 1'b1 && fc_ready === 1'b1)
    begin
      got.push_back(fc_char);
      fc_ready <= 1'b0;
      cnt <= 0;
    end
    else if (fc_valid === 1'b1)
    begin
      cnt <= cnt + 1;
      fc_ready <= (cnt >= slow);
    end
  end
  // ==========================================
  // modem line and transmitter state
  task set_line(input logic c, input logic b);
    cts_n <= c;
    tx_busy <= b;
  endtask
  task send(input logic [7:0] c);
    @(posedge core_clk);
    rx_valid <= 1'b1;
    rx_data <= c;
    @(posedge core_clk);
    rx_valid <= 1'b0;
    rx_data <= ~c;
  endtask
endmodule

// ### tb/ueflow_bench.sv
`timescale 1ns/1ps
`include "ueflow_defs.svh"
module ueflow_bench;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic        ce = 1'b1;
  logic [2:0]  hsize = 3'h0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [6:0]  rx_level = 7'h00;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, cts_n, rts_n, rx_trig_int, rx_valid;
  logic        tx_busy, tx_enable, fc_valid, fc_ready;
  logic [7:0]  fc_char, rx_data, r;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cycles = 0;
  always #2.5 core_clk = ~core_clk;
  ueflow_top u_ueflow_top (.core_clk(core_clk), .nrst(nrst), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .cts_n(cts_n), .rts_n(rts_n), .rx_trig_int(rx_trig_int), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_level(rx_level), .tx_busy(tx_busy), .tx_enable(tx_enable),
    .fc_valid(fc_valid), .fc_char(fc_char), .fc_ready(fc_ready));
  ueflow_remote u_ueflow_remote (.core_clk(core_clk), .rts_n(rts_n), .fc_valid(fc_valid),
    .fc_char(fc_char), .cts_n(cts_n), .rx_valid(rx_valid), .rx_data(rx_data),
    .fc_ready(fc_ready), .tx_busy(tx_busy));
  // ==========================================
  // shared tasks
  task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= {24'h0, d};
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    r = hrdata[7:0];
  endtask
  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_regs();
    bus(1'b0, `UEF_A_EFR, 8'h00);
    chk("efr reset", r, 8'h00);
    bus(1'b1, `UEF_A_SCRATCH, 8'ha5);
    bus(1'b0, `UEF_A_SCRATCH, 8'h00);
    chk("scratch", r, 8'ha5);
    chk("hresp", hresp, 1'b0);
    bus(1'b0, 8'hfc, 8'h00);
    chk("unmapped", r, 8'h00);
    bus(1'b1, `UEF_A_IER, 8'hf0);
    bus(1'b0, `UEF_A_IER, 8'h00);
    chk("ier locked", r & 8'hf0, 8'h00);
    bus(1'b1, `UEF_A_EFR, 8'h10);
    bus(1'b1, `UEF_A_IER, 8'hf0);
    bus(1'b1, `UEF_A_EFR, 8'h00);
    bus(1'b1, `UEF_A_IER, 8'h00);
    bus(1'b0, `UEF_A_IER, 8'h00);
    chk("ier latched", r & 8'hf0, 8'hf0);
    $display("registers done");
  endtask
  task automatic t_rts();
    logic [6:0] lv[5] = '{7'd0, 7'd8, 7'd16, 7'd7, 7'd6};
    logic       rt[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic       ti[5] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    bus(1'b1, `UEF_A_EFR, 8'h40);
    foreach (lv[i])
    begin
      rx_level <= lv[i];
      cyc(4);
      chk("rts", rts_n, rt[i]);
      chk("trigger", rx_trig_int, ti[i]);
    end
    ce <= 1'b0;
    rx_level <= 7'd16;
    cyc(4);
    chk("frozen", rts_n, 1'b0);
    ce <= 1'b1;
    rx_level <= 7'd0;
    bus(1'b1, `UEF_A_EFR, 8'h00);
    bus(1'b1, `UEF_A_MCR, 8'h02);
    cyc(3);
    chk("sw rts on", rts_n, 1'b0);
    bus(1'b1, `UEF_A_MCR, 8'h00);
    cyc(3);
    chk("sw rts off", rts_n, 1'b1);
    rx_level <= 7'd0;
    $display("rts done");
  endtask
  task automatic t_cts();
    u_ueflow_remote.set_line(1'b1, 1'b0);
    cyc(4);
    chk("cts ignored", tx_enable, 1'b1);
    u_ueflow_remote.set_line(1'b1, 1'b1);
    bus(1'b1, `UEF_A_EFR, 8'h80);
    cyc(4);
    chk("char finishes", tx_enable, 1'b1);
    u_ueflow_remote.set_line(1'b1, 1'b0);
    cyc(4);
    chk("cts halt", tx_enable, 1'b0);
    bus(1'b0, `UEF_A_STAT, 8'h00);
    chk("status", r, 8'h03);
    u_ueflow_remote.set_line(1'b0, 1'b0);
    cyc(4);
    chk("cts resume", tx_enable, 1'b1);
    $display("cts done");
  endtask
  task automatic t_txfc();
    logic [1:0] md[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
    logic [7:0] q[$];
    bus(1'b1, `UEF_A_RES1, 8'h11);
    bus(1'b1, `UEF_A_RES2, 8'h91);
    bus(1'b1, `UEF_A_PAU1, 8'h13);
    bus(1'b1, `UEF_A_PAU2, 8'h93);
    foreach (md[i])
    begin
      u_ueflow_remote.got = {};
      u_ueflow_remote.slow = i;
      bus(1'b1, `UEF_A_EFR, {4'h0, md[i], 2'h0});
      rx_level <= 7'd16;
      cyc(20);
      rx_level <= 7'd0;
      cyc(20);
      q = {};
      if (md[i][1]) q.push_back(8'h13);
      if (md[i][0]) q.push_back(8'h93);
      if (md[i][1]) q.push_back(8'h11);
      if (md[i][0]) q.push_back(8'h91);
      chk("fc count", 8'(u_ueflow_remote.got.size()), 8'(q.size()));
      foreach (q[k]) chk("fc char", u_ueflow_remote.got[k], q[k]);
    end
    $display("tx flow done");
  endtask
  task automatic t_rxfc();
    logic [1:0] md[3] = '{2'h2, 2'h1, 2'h3};
    foreach (md[i])
    begin
      bus(1'b1, `UEF_A_EFR, {6'h00, md[i]});
      if (md[i][1]) u_ueflow_remote.send(8'h13);
      if (md[i][0]) u_ueflow_remote.send(8'h93);
      cyc(4);
      chk("paused", tx_enable, 1'b0);
      if (md[i][1]) u_ueflow_remote.send(8'h11);
      if (md[i][0]) u_ueflow_remote.send(8'h91);
      cyc(4);
      chk("resumed", tx_enable, 1'b1);
    end
    $display("rx flow done");
  endtask
  task automatic t_spc();
    bus(1'b1, `UEF_A_EFR, 8'h30);
    u_ueflow_remote.send(8'h93);
    cyc(3);
    bus(1'b0, `UEF_A_ISR, 8'h00);
    chk("special", r & 8'h10, 8'h10);
    bus(1'b1, `UEF_A_ISR, 8'h00);
    u_ueflow_remote.send(8'h92);
    cyc(3);
    bus(1'b0, `UEF_A_ISR, 8'h00);
    chk("bit zero", r & 8'h10, 8'h00);
    bus(1'b1, `UEF_A_EFR, 8'h10);
    u_ueflow_remote.send(8'h93);
    cyc(3);
    bus(1'b0, `UEF_A_ISR, 8'h00);
    chk("detect off", r & 8'h10, 8'h00);
    $display("special done");
  endtask
  // ==========================================
  // sequence and timeout
  initial
  begin
    cyc(16);
    nrst <= 1'b1;
    cyc(3);
    chk("rts reset", rts_n, 1'b1);
    t_regs();
    t_rts();
    t_cts();
    t_txfc();
    t_rxfc();
    t_spc();
    report_and_stop();
  end
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_errors++;
      report_and_stop();
    end
  end
endmodule
